/* File: rtl/modem_change_detect.sv */
// Change detector on the synchronised clear-to-send level
`timescale 1ns/10ps
`default_nettype none

module modem_change_detect
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic level,
    output logic      change
);

    logic prev_ff;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            prev_ff <= 1'h0;
        else
            prev_ff <= level;
    end

    // Either direction counts
    assign change = level ^ prev_ff;

endmodule // modem_change_detect

`default_nettype wire

/* File: rtl/modem_sync2.sv */
// Two-flop synchroniser for the clear-to-send input
`timescale 1ns/10ps
`default_nettype none

module modem_sync2
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_ff;
    logic sync_ff;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_ff <= 1'h0;
            sync_ff <= 1'h0;
        end
        else
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule // modem_sync2

`default_nettype wire

/* File: rtl/uart_modem_flow_lines.sv */
// UART modem-line logic: RTS drive, CTS sensing, change interrupt
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none

module uart_modem_flow_lines
    import uart_modem_pkg::*;
#(
    parameter bit HAS_MODEM = 1'b1
)
(
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              cts_pin,
    output logic                   rts_pin,
    output logic                   cts_asserted,
    output logic                   modem_irq
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    wr_req_s     req_ff;
    logic        aw_held_ff;
    logic        w_held_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        rvalid_ff;
    logic [1:0]  rresp_ff;
    logic [31:0] rdata_ff;
    modem_ctl_s  ctl_ff;
    logic        flag_ff;
    logic        rts_pin_ff;
    logic        cts_asserted_ff;
    logic        irq_ff;
    logic        cts_sync;
    logic        cts_change;
    logic        do_write;
    logic        wr_ier;
    logic        wr_mcr;
    logic        wr_msr;
    logic        wr_mapped;
    logic        nxt_flag;
    logic        nxt_rts_pin;
    logic [31:0] rd_word;
    logic        rd_mapped;
    logic        ar_take;
    logic [1:0]  since_rst_ff;

    // ----------------------------------------------------------------
    // CTS input path
    // ----------------------------------------------------------------
    modem_sync2 u_cts_sync
    (
        .clk      (clk),
        .rstn     (rstn),
        .async_in (cts_pin),
        .sync_out (cts_sync)
    );

    modem_change_detect u_cts_change
    (
        .clk    (clk),
        .rstn   (rstn),
        .level  (cts_sync),
        .change (cts_change)
    );

    // ----------------------------------------------------------------
    // Write address and data channels
    // ----------------------------------------------------------------
    // Both channels taken independently; response waits for both
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready  = !w_held_ff && !bvalid_ff;
    assign do_write      = aw_held_ff && w_held_ff;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            aw_held_ff <= 1'h0;
            req_ff.addr <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_ff <= 1'h1;
            req_ff.addr <= s_axi_awaddr;
        end
        else if (do_write)
            aw_held_ff <= 1'h0;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            w_held_ff <= 1'h0;
            req_ff.data <= '0;
            req_ff.strb <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_ff <= 1'h1;
            req_ff.data <= s_axi_wdata;
            req_ff.strb <= s_axi_wstrb;
        end
        else if (do_write)
            w_held_ff <= 1'h0;
    end

    // ----------------------------------------------------------------
    // Write decode and response
    // ----------------------------------------------------------------
    // Modem locations stay mapped but inert on a channel without it
    assign wr_ier = do_write && req_ff.addr == OFF_INT_ENABLE;
    assign wr_mcr = do_write && req_ff.addr == OFF_MODEM_CONTROL
                    && HAS_MODEM;
    assign wr_msr = do_write && req_ff.addr == OFF_MODEM_STATUS
                    && HAS_MODEM;
    assign wr_mapped = req_ff.addr == OFF_INT_ENABLE
                    || req_ff.addr == OFF_MODEM_CONTROL
                    || req_ff.addr == OFF_MODEM_STATUS;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bvalid_ff <= 1'h0;
            bresp_ff  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_ff <= 1'h1;
            bresp_ff  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_ff <= 1'h0;
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    // ----------------------------------------------------------------
    // Control fields
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctl_ff.rts_ctl   <= MCR_RESET[MCR_RTS_CTL_BIT];
            ctl_ff.rts_level <= MCR_RESET[MCR_RTS_LEVEL_BIT];
        end
        else if (wr_mcr)
        begin
            if (req_ff.strb[MCR_RTS_CTL_BIT/8])
                ctl_ff.rts_ctl <= req_ff.data[MCR_RTS_CTL_BIT];
            if (req_ff.strb[MCR_RTS_LEVEL_BIT/8])
                ctl_ff.rts_level <= req_ff.data[MCR_RTS_LEVEL_BIT];
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ctl_ff.cts_level <= MSR_RESET[MSR_CTS_LEVEL_BIT];
        else if (wr_msr && req_ff.strb[MSR_CTS_LEVEL_BIT/8])
            ctl_ff.cts_level <= req_ff.data[MSR_CTS_LEVEL_BIT];
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ctl_ff.modem_int_enable <= IER_RESET[IER_MODEM_BIT];
        else if (wr_ier && req_ff.strb[IER_MODEM_BIT/8])
            ctl_ff.modem_int_enable <= req_ff.data[IER_MODEM_BIT];
    end

    // ----------------------------------------------------------------
    // RTS output
    // ----------------------------------------------------------------
    always_comb
    begin
        if (!HAS_MODEM)
            nxt_rts_pin = RTS_PIN_RESET;
        else if (ctl_ff.rts_level)
            nxt_rts_pin = ctl_ff.rts_ctl;
        else
            nxt_rts_pin = !ctl_ff.rts_ctl;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rts_pin_ff <= RTS_PIN_RESET;
        else
            rts_pin_ff <= nxt_rts_pin;
    end

    assign rts_pin = rts_pin_ff;

    // ----------------------------------------------------------------
    // CTS sense and change flag
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cts_asserted_ff <= 1'h0;
        else
            cts_asserted_ff <= HAS_MODEM
                               && (cts_sync == ctl_ff.cts_level);
    end

    assign cts_asserted = cts_asserted_ff;

    // A change in the clearing cycle survives the clear
    always_comb
    begin
        nxt_flag = flag_ff;
        if (wr_msr && req_ff.strb[MSR_CHANGE_BIT/8]
            && req_ff.data[MSR_CHANGE_BIT])
            nxt_flag = 1'h0;
        if (cts_change && HAS_MODEM)
            nxt_flag = 1'h1;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            flag_ff <= MSR_RESET[MSR_CHANGE_BIT];
        else
            flag_ff <= nxt_flag;
    end

    // ----------------------------------------------------------------
    // Interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            irq_ff <= 1'h0;
        else
            irq_ff <= nxt_flag && ctl_ff.modem_int_enable;
    end

    assign modem_irq = irq_ff;

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_word   = '0;
        rd_mapped = 1'h1;
        unique case (s_axi_araddr)
            OFF_INT_ENABLE:
                rd_word[IER_MODEM_BIT] = ctl_ff.modem_int_enable;
            OFF_MODEM_CONTROL:
            begin
                rd_word[MCR_RTS_CTL_BIT]   = ctl_ff.rts_ctl;
                rd_word[MCR_RTS_LEVEL_BIT] = ctl_ff.rts_level;
                rd_word[MCR_RTS_STATE_BIT] = rts_pin_ff;
            end
            OFF_MODEM_STATUS:
            begin
                rd_word[MSR_CHANGE_BIT]    = flag_ff;
                rd_word[MSR_CTS_STATE_BIT] = cts_sync;
                rd_word[MSR_CTS_LEVEL_BIT] = ctl_ff.cts_level;
            end
            default:
                rd_mapped = 1'h0;
        endcase
        if (!HAS_MODEM && s_axi_araddr != OFF_INT_ENABLE)
            rd_word = '0;
    end

    assign s_axi_arready = !rvalid_ff;
    assign ar_take       = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rvalid_ff <= 1'h0;
            rresp_ff  <= RESP_OKAY;
            rdata_ff  <= '0;
        end
        else if (ar_take)
        begin
            rvalid_ff <= 1'h1;
            rresp_ff  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            rdata_ff  <= rd_word;
        end
        else if (s_axi_rready)
            rvalid_ff <= 1'h0;
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp  = rresp_ff;
    assign s_axi_rdata  = rdata_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            since_rst_ff <= 2'h0;
        else if (since_rst_ff != 2'h3)
            since_rst_ff <= since_rst_ff + 2'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_rts_high_on: assert property (
        HAS_MODEM && ctl_ff.rts_level && ctl_ff.rts_ctl |=> rts_pin)
        else $error("RTS not high with active-high request");

    chk_rts_active_low: assert property (
        HAS_MODEM && !ctl_ff.rts_level
        |=> rts_pin == !$past(ctl_ff.rts_ctl))
        else $error("RTS pin wrong with active-low polarity");

    chk_rts_active_high: assert property (
        HAS_MODEM && ctl_ff.rts_level
        |=> rts_pin == $past(ctl_ff.rts_ctl))
        else $error("RTS pin wrong with active-high polarity");

    chk_cts_polarity: assert property (
        HAS_MODEM
        |=> cts_asserted == ($past(cts_sync) == $past(ctl_ff.cts_level)))
        else $error("CTS asserted ignores polarity");

    chk_cts_state_read: assert property (
        HAS_MODEM && ar_take && s_axi_araddr == OFF_MODEM_STATUS
        |=> s_axi_rdata[MSR_CTS_STATE_BIT] == $past(cts_sync))
        else $error("CTS state bit does not show the pin");

    chk_change_sets: assert property (
        HAS_MODEM && since_rst_ff == 2'h3 && $changed(cts_sync)
        |=> flag_ff)
        else $error("CTS change did not set the flag");

    chk_irq_follows: assert property (
        1 |=> modem_irq == (flag_ff && $past(ctl_ff.modem_int_enable)))
        else $error("Modem interrupt does not match flag and enable");

    chk_w1c_clear: assert property (
        wr_msr && req_ff.strb[0] && req_ff.data[MSR_CHANGE_BIT]
        && !cts_change |=> !flag_ff && !modem_irq)
        else $error("Write of one did not clear the flag");

    chk_w0_keep: assert property (
        flag_ff && !(wr_msr && req_ff.strb[0]
        && req_ff.data[MSR_CHANGE_BIT]) |=> flag_ff)
        else $error("Flag lost without a clearing write");

    chk_no_modem: assert property (
        !HAS_MODEM |-> !modem_irq && rts_pin == RTS_PIN_RESET
        && !cts_asserted)
        else $error("Channel without modem shows modem activity");

    chk_msr_reset: assert property (
        since_rst_ff == 2'h0 |-> !flag_ff && !cts_sync
        && !ctl_ff.cts_level)
        else $error("Modem status not zero after reset");

    chk_rts_state_read: assert property (
        HAS_MODEM && ar_take && s_axi_araddr == OFF_MODEM_CONTROL
        |=> s_axi_rdata[MCR_RTS_STATE_BIT] == $past(rts_pin))
        else $error("RTS state bit does not show the driven pin");

    chk_sync_delay: assert property (
        since_rst_ff == 2'h3 |-> cts_sync == $past(cts_pin, 2))
        else $error("CTS synchroniser delay is not two cycles");

endmodule // uart_modem_flow_lines

`default_nettype wire

/* File: rtl/uart_modem_pkg.sv */
// Constants and carrier types for the UART modem-line block
package uart_modem_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int          ADDR_W            = 12;
    localparam logic [11:0] OFF_INT_ENABLE    = 12'h004;
    localparam logic [11:0] OFF_MODEM_CONTROL = 12'h010;
    localparam logic [11:0] OFF_MODEM_STATUS  = 12'h014;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int MCR_RTS_CTL_BIT   = 1;
    localparam int MCR_RTS_LEVEL_BIT = 9;
    localparam int MCR_RTS_STATE_BIT = 13;
    localparam int MSR_CHANGE_BIT    = 0;
    localparam int MSR_CTS_STATE_BIT = 4;
    localparam int MSR_CTS_LEVEL_BIT = 8;
    localparam int IER_MODEM_BIT     = 3;

    // ----------------------------------------------------------------
    // Reset values and bus answers
    // ----------------------------------------------------------------
    localparam logic [31:0] MCR_RESET     = 32'h0000_0000;
    localparam logic [31:0] MSR_RESET     = 32'h0000_0000;
    localparam logic [31:0] IER_RESET     = 32'h0000_0000;
    localparam logic        RTS_PIN_RESET = 1'h1;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic rts_level;
        logic rts_ctl;
        logic cts_level;
        logic modem_int_enable;
    } modem_ctl_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       data;
        logic [3:0]        strb;
    } wr_req_s;

endpackage

/* File: testbench/modem_peer.sv */
// Behavioural modem or peer device on the RTS/CTS lines
`timescale 1ns/10ps
`default_nettype none

module modem_peer
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       rts_pin,
    input  wire logic       loop_en,
    input  wire logic [2:0] lag,
    input  wire logic       cts_set,
    output logic            cts_pin
);
    // ----------------------------------------------------------------
    // Loopback history of the request line
    // ----------------------------------------------------------------
    logic [7:0] hist_ff;

    // Slow answers come from deeper taps of the history
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            hist_ff <= 8'h00;
        else
            hist_ff <= {hist_ff[6:0], rts_pin};
    end

    assign cts_pin = loop_en ? hist_ff[lag] : cts_set;
endmodule // modem_peer

`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the UART modem-line block
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import uart_modem_pkg::*;
;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] wd;
        logic [31:0] rd;
        logic [1:0]  resp;
        logic        rts;
    } row_s;

    logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        rts_pin, cts_pin, cts_asserted, modem_irq;
    logic        rts3, irq3, loop_en, cts_set;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rdata3, rd, rd3;
    logic [1:0]  bresp, rresp, resp;
    logic [2:0]  lag;
    logic [3:0]  wstrb;
    int          errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    row_s rows [8] = '{
        '{12'h010, 32'h0000_0202, 32'h0000_2202, 2'h0, 1'h1},
        '{12'h010, 32'h0000_0200, 32'h0000_0200, 2'h0, 1'h0},
        '{12'h010, 32'h0000_0002, 32'h0000_0002, 2'h0, 1'h0},
        '{12'h010, 32'hffff_ffff, 32'h0000_2202, 2'h0, 1'h1},
        '{12'h010, 32'h0000_0000, 32'h0000_2000, 2'h0, 1'h1},
        '{12'h004, 32'hffff_ffff, 32'h0000_0008, 2'h0, 1'h1},
        '{12'h004, 32'h0000_0000, 32'h0000_0000, 2'h0, 1'h1},
        '{12'h020, 32'hffff_ffff, 32'h0000_0000, 2'h2, 1'h1}};

    // ----------------------------------------------------------------
    // Design, third-channel variant and far-side model
    // ----------------------------------------------------------------
    uart_modem_flow_lines dut (.clk(clk), .rstn(rstn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_rready(rready),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .cts_pin(cts_pin), .rts_pin(rts_pin),
        .cts_asserted(cts_asserted), .modem_irq(modem_irq));

    // Shares the bus; its handshake timing is the same logic as dut's
    uart_modem_flow_lines #(.HAS_MODEM(1'b0)) dut3 (.clk(clk), .rstn(rstn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(),
        .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_rready(rready),
        .s_axi_arready(), .s_axi_rdata(rdata3), .s_axi_rresp(),
        .s_axi_rvalid(), .cts_pin(cts_pin), .rts_pin(rts3),
        .cts_asserted(), .modem_irq(irq3));

    modem_peer peer (.clk(clk), .rstn(rstn), .rts_pin(rts_pin),
        .loop_en(loop_en), .lag(lag), .cts_set(cts_set), .cts_pin(cts_pin));

    // ----------------------------------------------------------------
    // Clock, watchdog and shared tasks
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        while (!(aw_ok && w_ok))
        begin
            @(posedge clk);
            if (!aw_ok && awready === 1'b1)
            begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rd = rdata;
        rd3 = rdata3;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {rstn, awvalid, wvalid, bready, arvalid, rready} <= 6'h00;
        {awaddr, araddr, wdata} <= 56'h0;
        {loop_en, cts_set, lag} <= 5'h00;
        wstrb <= 4'hf;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        axi_read(OFF_MODEM_STATUS);
        check(rd, MSR_RESET);
        axi_read(OFF_MODEM_CONTROL);
        check(rd, 32'h0000_2000);
        #1 check(rts_pin, 1'b1);
        check(modem_irq, 1'b0);
        $display("test reset done");

        foreach (rows[i])
        begin
            axi_write(rows[i].a, rows[i].wd);
            check(resp, rows[i].resp);
            axi_read(rows[i].a);
            check(rd, rows[i].rd);
            check(resp, rows[i].resp);
            #1 check(rts_pin, rows[i].rts);
            if (rows[i].a == OFF_MODEM_CONTROL)
                check(rd3, 32'h0);
        end
        $display("test register table done");

        // Edge counts pin the three-cycle delay from pin to interrupt
        axi_write(OFF_INT_ENABLE, 32'h8);
        @(posedge clk);
        cts_set <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check(modem_irq, 1'b0);
        @(posedge clk);
        #1 check(modem_irq, 1'b1);
        axi_read(OFF_MODEM_STATUS);
        check(rd, 32'h11);
        check(rd3, 32'h0);
        check(cts_asserted, 1'b0);
        axi_write(OFF_MODEM_STATUS, 32'h100);
        axi_read(OFF_MODEM_STATUS);
        check(rd, 32'h111);
        check(cts_asserted, 1'b1);
        axi_write(OFF_MODEM_STATUS, 32'h101);
        axi_read(OFF_MODEM_STATUS);
        check(rd, 32'h110);
        check(modem_irq, 1'b0);
        cts_set <= 1'b0;
        repeat (6) @(posedge clk);
        axi_read(OFF_MODEM_STATUS);
        check(rd, 32'h101);
        check(cts_asserted, 1'b0);
        check(modem_irq, 1'b1);
        axi_write(OFF_INT_ENABLE, 32'h0);
        repeat (3) @(posedge clk);
        #1 check(modem_irq, 1'b0);
        check({rts3, irq3}, 2'h2);
        axi_write(OFF_MODEM_STATUS, 32'h1);
        axi_read(OFF_MODEM_STATUS);
        check(rd, 32'h0);
        $display("test clear-to-send done");

        // Slow peer: CTS echoes RTS eight cycles late
        loop_en <= 1'b1;
        lag <= 3'h7;
        repeat (8) @(posedge clk);
        axi_read(OFF_MODEM_STATUS);
        check(rd, 32'h11);
        axi_write(OFF_MODEM_STATUS, 32'h1);
        axi_write(OFF_MODEM_CONTROL, 32'h200);
        repeat (12) @(posedge clk);
        axi_read(OFF_MODEM_STATUS);
        check(rd, 32'h01);
        $display("test loopback done");

        // Upper byte lane off: polarity bit must keep its value
        wstrb <= 4'h1;
        axi_write(OFF_MODEM_CONTROL, 32'h0000_0002);
        wstrb <= 4'hf;
        axi_read(OFF_MODEM_CONTROL);
        check(rd, 32'h0000_2202);
        // Mid-run reset must bring both modem registers back
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        axi_read(OFF_MODEM_CONTROL);
        check(rd, 32'h0000_2000);
        axi_read(OFF_MODEM_STATUS);
        check(rd, MSR_RESET);
        $display("test strobe and reset done");
        print_verdict();
    end
endmodule // tb_top

`default_nettype wire
